// ==== sim/cebi_mem_model.sv ====
// Behavioural external memory on the expansion bus
module cebi_mem_model
  import cebi_pkg::*;
(
  input wire logic        phase2_clk,
  input wire logic        read_write,
  input wire logic        opcode_sync,
  input wire logic [13:0] addr_out,
  input wire logic        port_c_line6_addr13,
  input wire logic        port_c_line7_addr14,
  input wire logic [7:0]  data_lines_out,
  input wire logic [7:0]  data_lines_oe_n,
  output logic     [7:0]  data_lines_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [65536];
  logic [15:0] last_addr;
  logic        last_rw;
  logic        last_sync;
  int          n_cyc;
  wire  [15:0] a = {addr_out[13], port_c_line7_addr14, port_c_line6_addr13, addr_out[12:0]};
  // Pattern fill
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ i[15:8];
    data_lines_in = 8'h00;
    n_cyc = 0;
  end
  // Record each bus cycle, take write data once settled
  always @(posedge phase2_clk) begin
    last_addr = a;
    last_rw = read_write;
    last_sync = opcode_sync;
    n_cyc++;
    #2;
    if (!read_write && data_lines_oe_n === 8'h00)
      mem[a] = data_lines_out;
  end
  // Read data in phase two only, inverse junk when released
  always @(phase2_clk) begin
    #1;
    if (phase2_clk && read_write)
      data_lines_in = mem[a];
    else
      data_lines_in = ~data_lines_in;
  end
endmodule : cebi_mem_model

// ==== sim/cebi_top_checker.sv ====
// Pin timing checker for the external bus interface
module cebi_top_checker
  import cebi_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        power_on_init_n,
  input wire logic        nmi_n,
  input wire logic        core_nmi,
  input wire logic        cpu_reset_n,
  input wire logic        phase2_clk,
  input wire logic        opcode_sync,
  input wire logic        read_write,
  input wire logic [13:0] addr_out,
  input wire logic [7:0]  data_lines_oe_n,
  input wire logic [7:0]  fourth_port_lines_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  a_sync_whole: assert property ($fell(opcode_sync) |-> $fell(phase2_clk))
    else $error("fetch marker ended apart from phase two");
  a_sync_read: assert property (opcode_sync |-> read_write)
    else $error("fetch marker during a write");
  a_wr_drive: assert property (!read_write && phase2_clk |-> data_lines_oe_n == 8'h00)
    else $error("write data not driven in phase two");
  a_no_contend: assert property (!(phase2_clk && !read_write) |-> data_lines_oe_n == 8'hFF)
    else $error("data drivers on outside write phase two");
  a_addr_hold: assert property (phase2_clk && $past(phase2_clk)
    |-> $stable(addr_out) && $stable(read_write))
    else $error("address or direction moved in phase two");
  a_wr_reaches: assert property ($fell(read_write) |-> ##[1:40] phase2_clk)
    else $error("write cycle never reached phase two");
  a_nmi_raise: assert property ($fell(nmi_n) && power_on_init_n
    |-> ##[1:5] (core_nmi || !power_on_init_n))
    else $error("falling nmi edge not raised");
  a_init_fwd: assert property ($fell(power_on_init_n) |-> ##[1:3] !cpu_reset_n)
    else $error("init pin not forwarded");
  a_port_whole: assert property (fourth_port_lines_oe_n inside {8'h00, 8'hFF})
    else $error("fourth port split direction");
endmodule : cebi_top_checker

bind cebi_top cebi_top_checker i_chk (.*);

// ==== sim/tb_top.sv ====
// Self-checking bench for the external bus interface
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_top
  import cebi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] md; logic full; logic [15:0] a; logic [7:0] d;} cebi_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_input, osc_output_grounded;
  logic power_on_init_n, nmi_n, core_nmi, cpu_reset_n, phase2_clk, opcode_sync, read_write;
  logic port_c_line6_addr13, port_c_line7_addr14, err;
  logic [7:0] paddr, data_lines_in, data_lines_out, data_lines_oe_n;
  logic [7:0] fourth_port_lines_out, fourth_port_lines_oe_n, fourth_port_lines_in;
  logic [13:0] addr_out;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt, n_checks, cnt;
  cebi_row_t rows[6] = '{'{2'h1, 1'h1, 16'h7ABC, 8'h5A}, '{2'h0, 1'h1, 16'h7ABC, 8'h5A},
    '{2'h2, 1'h0, 16'hE123, 8'hA2}, '{2'h1, 1'h0, 16'h0001, 8'hC3},
    '{2'h2, 1'h1, 16'h0001, 8'hC3}, '{2'h0, 1'h0, 16'hFFFF, 8'h60}};
  cebi_top i_dut (.*);
  cebi_mem_model i_mem (.*);
  ////////////////////////////////////////////////////////////////////////
  // Clocks: system and oscillator pin
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    osc_input = 0;
    #3;
    forever #100 osc_input = ~osc_input;
  end
  // One APB transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll until the bus cycle is over
  task automatic bus_wait;
    repeat (100) begin
      apb(1'b0, CEBI_STATUS_OFF, 32'h0);
      if (rd[CEBI_ST_BUSY_BIT] === 1'b0) break;
    end
    `CHK("bus_idle", 1'b0, rd[CEBI_ST_BUSY_BIT])
  endtask : bus_wait
  task automatic give_verdict;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, power_on_init_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {nmi_n, osc_output_grounded, fourth_port_lines_in} = {2'h3, 8'h3C};
    repeat (3) @(posedge pclk);
    `CHK("rw_rst", 1'b1, read_write)
    `CHK("oe_rst", 8'hFF, data_lines_oe_n)
    `CHK("pd_rst", 8'hFF, fourth_port_lines_oe_n)
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    power_on_init_n <= 1'b1;
    apb(1'b0, CEBI_CTRL_OFF, 32'h0);
    `CHK("ctrl_rst", CEBI_CTRL_RST, rd)
    `CHK("nmi_idle", 1'b0, core_nmi)
    foreach (rows[i]) begin
      apb(1'b1, CEBI_CTRL_OFF, {31'h0, rows[i].full});
      apb(1'b1, CEBI_ADDR_OFF, {16'h0, rows[i].a});
      apb(1'b1, CEBI_WDATA_OFF, {24'h0, rows[i].d});
      apb(1'b1, CEBI_CMD_OFF, {30'h0, rows[i].md == 2'h2, rows[i].md == 2'h1});
      bus_wait;
      apb(1'b0, CEBI_RDATA_OFF, 32'h0);
      if (rows[i].md != 2'h1) `CHK("rdata", rows[i].d, rd[7:0])
      else `CHK("mem", rows[i].d, i_mem.mem[rows[i].a])
      `CHK("addr", rows[i].full ? rows[i].a : rows[i].a & 16'h9FFF, i_mem.last_addr)
      `CHK("rw", rows[i].md != 2'h1, i_mem.last_rw)
      `CHK("sync", rows[i].md == 2'h2, i_mem.last_sync)
    end
    // Command while busy is dropped
    cnt = i_mem.n_cyc;
    apb(1'b1, CEBI_ADDR_OFF, 32'h2);
    apb(1'b1, CEBI_WDATA_OFF, 32'h77);
    apb(1'b1, CEBI_CMD_OFF, 32'h1);
    apb(1'b1, CEBI_CMD_OFF, 32'h2);
    bus_wait;
    `CHK("one_cycle", cnt + 1, i_mem.n_cyc)
    `CHK("wr_kept", 8'h77, i_mem.mem[2])
    apb(1'b0, 8'h20, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
    // Phase two length for each oscillator setup
    for (int k = 0; k < 3; k++) begin
      osc_output_grounded <= (k == 0);
      apb(1'b1, CEBI_CTRL_OFF, {29'h0, k == 1, 2'h0});
      apb(1'b0, CEBI_STATUS_OFF, 32'h0);
      `CHK("div1", k == 0, rd[CEBI_ST_DIV1_BIT])
      apb(1'b1, CEBI_CMD_OFF, 32'h0);
      cnt = 0;
      repeat (200) @(negedge pclk) if (phase2_clk === 1'b1) cnt++;
      `CHK("ph2_len", 8 << k, cnt)
    end
    apb(1'b1, CEBI_CTRL_OFF, 32'h102);
    apb(1'b1, CEBI_PORTD_OFF, 32'hA5);
    repeat (2) @(negedge pclk);
    `CHK("pc_lines", 2'h1, {port_c_line7_addr14, port_c_line6_addr13})
    `CHK("pd_out", 8'hA5, fourth_port_lines_out)
    `CHK("pd_drv", 8'h00, fourth_port_lines_oe_n)
    apb(1'b1, CEBI_CTRL_OFF, 32'h0);
    apb(1'b0, CEBI_PIND_OFF, 32'h0);
    `CHK("pd_in", 32'h3C, rd)
    `CHK("pd_off", 8'hFF, fourth_port_lines_oe_n)
    // Edge request, clear, then init pin
    nmi_n <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK("nmi", 1'b1, core_nmi)
    nmi_n <= 1'b1;
    apb(1'b1, CEBI_STATUS_OFF, 32'h2);
    @(posedge pclk);
    `CHK("nmi_clr", 1'b0, core_nmi)
    nmi_n <= 1'b0;
    repeat (6) @(posedge pclk);
    power_on_init_n <= 1'b0;
    repeat (8) @(posedge pclk);
    `CHK("init", 1'b0, cpu_reset_n)
    `CHK("init_nmi", 1'b0, core_nmi)
    power_on_init_n <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("init_off", 1'b1, cpu_reset_n)
    give_verdict;
  end
endmodule : tb_top

// ==== src/cebi_clkgen.sv ====
// Oscillator input divider producing the bus phase strobe
module cebi_clkgen
  import cebi_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic osc_sync,
  input  wire logic div_by_one,
  input  wire logic fast_part,
  output logic      phase_tick
);

  logic       osc_prev;
  logic       osc_rise;
  logic [1:0] div_cnt;
  logic [1:0] div_max;

  // Rising edge of the sampled oscillator input
  assign osc_rise = osc_sync & ~osc_prev;
  assign div_max  = fast_part ? CEBI_DIV_FAST : CEBI_DIV_SLOW;

  // Edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= osc_sync;
    end
  end

  // Divide by one, two or four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt    <= 2'h0;
      phase_tick <= 1'b0;
    end else if (osc_rise) begin
      if (div_by_one || div_cnt >= div_max) begin
        div_cnt    <= 2'h0;
        phase_tick <= 1'b1;
      end else begin
        div_cnt    <= div_cnt + 2'h1;
        phase_tick <= 1'b0;
      end
    end else begin
      phase_tick <= 1'b0;
    end
  end

endmodule : cebi_clkgen

// ==== src/cebi_pkg.sv ====
// Package for the external bus interface: offsets, fields, reset values, timing
package cebi_pkg;

  // APB register byte offsets
  localparam logic [7:0] CEBI_CTRL_OFF   = 8'h00;
  localparam logic [7:0] CEBI_CMD_OFF    = 8'h04;
  localparam logic [7:0] CEBI_ADDR_OFF   = 8'h08;
  localparam logic [7:0] CEBI_WDATA_OFF  = 8'h0C;
  localparam logic [7:0] CEBI_STATUS_OFF = 8'h10;
  localparam logic [7:0] CEBI_RDATA_OFF  = 8'h14;
  localparam logic [7:0] CEBI_PORTD_OFF  = 8'h18;
  localparam logic [7:0] CEBI_PIND_OFF   = 8'h1C;

  // Control register fields
  localparam int CEBI_CTRL_FULLADDR_BIT = 0;
  localparam int CEBI_CTRL_PDOUT_BIT    = 1;
  localparam int CEBI_CTRL_FAST_BIT     = 2;
  localparam int CEBI_CTRL_PORTC_LSB    = 8;

  // Command register fields
  localparam int CEBI_CMD_WRITE_BIT = 0;
  localparam int CEBI_CMD_FETCH_BIT = 1;

  // Status register fields
  localparam int CEBI_ST_BUSY_BIT = 0;
  localparam int CEBI_ST_NMI_BIT  = 1;
  localparam int CEBI_ST_DIV1_BIT = 2;

  // Reset values
  localparam logic [31:0] CEBI_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0]  CEBI_BYTE_RST = 8'h00;

  // Oscillator divider terminal counts (divide ratio minus one: four and two)
  localparam logic [1:0] CEBI_DIV_SLOW = 2'h3;
  localparam logic [1:0] CEBI_DIV_FAST = 2'h1;

  // Reset source must hold low this many input clock cycles
  localparam int CEBI_RESET_HOLD_CYC = 8;

  // Bus cycle phases
  typedef enum logic [1:0] {
    CEBI_IDLE,
    CEBI_PH1,
    CEBI_PH2
  } cebi_state_t;

endpackage : cebi_pkg

// ==== src/cebi_sync.sv ====
// Two flip-flop synchroniser for pin inputs
module cebi_sync
  import cebi_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : cebi_sync

// ==== src/cebi_top.sv ====
// External expansion bus interface with clock, reset and NMI pins
//
// Behaviour
// - The fetch marker is high for one whole bus cycle per opcode fetch, low otherwise.
// - The direction output is high for external reads and low for external writes.
// - Address bits 0 to 12 and 15 leave on fourteen dedicated address outputs.
// - In full address mode bits 13 and 14 replace data on the top two third-port lines.
// - Data lines carry bytes out when writing and in from memory when reading.
// - A falling edge on the non-maskable input raises a non-maskable request.
// - Grounded crystal output uses the clock as is; floating output divides by four or two.
// - A phase-two strobe, high for the whole second phase of each bus cycle (one divided oscillator period) and low when idle, is driven out as the bus reference.
// - The fourth port is a whole 8-bit input or a whole 8-bit actively driven output.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
module cebi_top
  import cebi_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_input,
  input  wire logic        osc_output_grounded,
  input  wire logic        power_on_init_n,
  input  wire logic        nmi_n,
  output logic             core_nmi,
  output logic             cpu_reset_n,
  output logic             phase2_clk,
  output logic             opcode_sync,
  output logic             read_write,
  output logic      [13:0] addr_out,
  input  wire logic [7:0]  data_lines_in,
  output logic      [7:0]  data_lines_out,
  output logic      [7:0]  data_lines_oe_n,
  output logic             port_c_line6_addr13,
  output logic             port_c_line7_addr14,
  output logic      [7:0]  fourth_port_lines_out,
  output logic      [7:0]  fourth_port_lines_oe_n,
  input  wire logic [7:0]  fourth_port_lines_in
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [7:0] data_sync;
  logic [7:0] portd_sync;
  logic [3:0] misc_sync;
  logic       osc_sync;
  logic       grounded_sync;
  logic       init_n_sync;
  logic       nmi_sync;

  cebi_sync #(.WIDTH(8)) u_sync_data (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (data_lines_in),
    .sync_out (data_sync)
  );

  cebi_sync #(.WIDTH(8)) u_sync_portd (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (fourth_port_lines_in),
    .sync_out (portd_sync)
  );

  cebi_sync #(.WIDTH(4)) u_sync_misc (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({osc_input, osc_output_grounded, power_on_init_n, nmi_n}),
    .sync_out (misc_sync)
  );

  assign osc_sync      = misc_sync[3];
  assign grounded_sync = misc_sync[2];
  assign init_n_sync   = misc_sync[1];
  assign nmi_sync      = misc_sync[0];

  //////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode

  logic [31:0] ctrl;
  logic [15:0] bus_addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  portd_out;
  logic        cmd_pending;
  logic        cmd_write;
  logic        cmd_fetch;
  logic        nmi_flag;
  logic        busy;
  logic        wr_en;
  logic        rd_en;
  logic        cmd_hit;
  logic        nmi_clr;
  logic        nmi_edge;
  logic        phase_tick;

  // Address is mapped when it matches a defined word
  function automatic logic cebi_mapped(input logic [7:0] a);
    case (a)
      CEBI_CTRL_OFF, CEBI_CMD_OFF, CEBI_ADDR_OFF, CEBI_WDATA_OFF,
      CEBI_STATUS_OFF, CEBI_RDATA_OFF, CEBI_PORTD_OFF, CEBI_PIND_OFF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : cebi_mapped

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~cebi_mapped(paddr);
  assign wr_en   = psel & penable & pwrite & cebi_mapped(paddr);
  assign rd_en   = psel & ~penable & ~pwrite; // Setup cycle of a read
  assign cmd_hit = wr_en && (paddr == CEBI_CMD_OFF) && !busy;
  assign nmi_clr = wr_en && (paddr == CEBI_STATUS_OFF) && pwdata[CEBI_ST_NMI_BIT];

  // Software written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= CEBI_CTRL_RST;
      bus_addr  <= 16'h0000;
      wdata     <= CEBI_BYTE_RST;
      portd_out <= CEBI_BYTE_RST;
    end else if (wr_en) begin
      case (paddr)
        CEBI_CTRL_OFF:  ctrl      <= pwdata;
        CEBI_ADDR_OFF:  bus_addr  <= pwdata[15:0];
        CEBI_WDATA_OFF: wdata     <= pwdata[7:0];
        CEBI_PORTD_OFF: portd_out <= pwdata[7:0];
        default:        ctrl      <= ctrl;
      endcase
    end
  end

  // Read mux, registered data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        CEBI_CTRL_OFF:   prdata <= ctrl;
        CEBI_ADDR_OFF:   prdata <= {16'h0000, bus_addr};
        CEBI_WDATA_OFF:  prdata <= {24'h000000, wdata};
        CEBI_STATUS_OFF: prdata <= {29'h0, grounded_sync, nmi_flag, busy};
        CEBI_RDATA_OFF:  prdata <= {24'h000000, rdata};
        CEBI_PORTD_OFF:  prdata <= {24'h000000, portd_out};
        CEBI_PIND_OFF:   prdata <= {24'h000000, portd_sync};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset and NMI

  logic nmi_prev;

  // Core held in reset while pin is low; source keeps it low long enough
  assign cpu_reset_n = init_n_sync;

  // Falling edge of the NMI pin sets a sticky flag, set beats clear
  assign nmi_edge = nmi_prev & ~nmi_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Same level as the synchroniser after reset, so no false edge
      nmi_prev <= 1'b0;
      nmi_flag <= 1'b0;
    end else begin
      nmi_prev <= nmi_sync;
      if (nmi_edge) begin
        nmi_flag <= 1'b1;
      end else if (nmi_clr || !init_n_sync) begin
        nmi_flag <= 1'b0;
      end
    end
  end

  assign core_nmi = nmi_flag;

  //////////////////////////////////////////////////////////////////////////////
  // Clock generation

  cebi_clkgen u_clkgen (
    .pclk       (pclk),
    .presetn    (presetn),
    .osc_sync   (osc_sync),
    .div_by_one (grounded_sync),
    .fast_part  (ctrl[CEBI_CTRL_FAST_BIT]),
    .phase_tick (phase_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer

  cebi_state_t state;
  cebi_state_t next_state;

  // Busy from command capture until the bus cycle ends
  assign busy = cmd_pending | (state != CEBI_IDLE);

  // Phase sequencing on divided ticks
  always_comb begin
    next_state = state;
    case (state)
      CEBI_IDLE: if (cmd_pending && phase_tick) next_state = CEBI_PH1;
      CEBI_PH1:  if (phase_tick) next_state = CEBI_PH2;
      CEBI_PH2:  if (phase_tick) next_state = CEBI_IDLE;
      default:   next_state = CEBI_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CEBI_IDLE;
    end else if (!init_n_sync) begin
      state <= CEBI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Command capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pending <= 1'b0;
      cmd_write   <= 1'b0;
      cmd_fetch   <= 1'b0;
    end else if (cmd_hit) begin
      cmd_pending <= 1'b1;
      cmd_write   <= pwdata[CEBI_CMD_WRITE_BIT];
      cmd_fetch   <= pwdata[CEBI_CMD_FETCH_BIT] & ~pwdata[CEBI_CMD_WRITE_BIT];
    end else if (state == CEBI_IDLE && next_state == CEBI_PH1) begin
      cmd_pending <= 1'b0;
    end
  end

  // Bus pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase2_clk      <= 1'b0;
      opcode_sync     <= 1'b0;
      read_write      <= 1'b1;
      addr_out        <= 14'h0000;
      data_lines_out  <= CEBI_BYTE_RST;
      data_lines_oe_n <= 8'hFF;
      rdata           <= CEBI_BYTE_RST;
    end else begin
      phase2_clk <= (next_state == CEBI_PH2);
      if (state == CEBI_IDLE && next_state == CEBI_PH1) begin
        addr_out    <= {bus_addr[15], bus_addr[12:0]};
        read_write  <= ~cmd_write;
        opcode_sync <= cmd_fetch;
      end else if (state == CEBI_PH2 && next_state == CEBI_IDLE) begin
        opcode_sync <= 1'b0;
        read_write  <= 1'b1;
        if (!cmd_write) begin
          rdata <= data_sync;
        end
      end
      // Drive only during the write data phase
      if (next_state == CEBI_PH2 && cmd_write) begin
        data_lines_out  <= wdata;
        data_lines_oe_n <= 8'h00;
      end else begin
        data_lines_oe_n <= 8'hFF;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Third port top lines and fourth port

  // Upper address bits or port data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_line6_addr13 <= 1'b1;
      port_c_line7_addr14 <= 1'b1;
    end else if (ctrl[CEBI_CTRL_FULLADDR_BIT]) begin
      port_c_line6_addr13 <= bus_addr[13];
      port_c_line7_addr14 <= bus_addr[14];
    end else begin
      port_c_line6_addr13 <= ctrl[CEBI_CTRL_PORTC_LSB];
      port_c_line7_addr14 <= ctrl[CEBI_CTRL_PORTC_LSB + 1];
    end
  end

  // Whole-port direction, push-pull drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fourth_port_lines_out  <= CEBI_BYTE_RST;
      fourth_port_lines_oe_n <= 8'hFF;
    end else begin
      fourth_port_lines_out  <= portd_out;
      fourth_port_lines_oe_n <= {8{~ctrl[CEBI_CTRL_PDOUT_BIT]}};
    end
  end

endmodule : cebi_top
